/* File: include/sled_cfg.svh */
/*
  Timing constants for the status indicator block.
  Assumes a 20 MHz clock; included by the two design files, not by the package.
*/
`ifndef SLED_CFG_SVH
`define SLED_CFG_SVH
`define SLED_CLK_HZ        20000000
`define SLED_TICK_HZ       1000
`define SLED_TICK_CYC      (`SLED_CLK_HZ / `SLED_TICK_HZ)
`define SLED_MINOR_S       10
`define SLED_MINOR_MS      (`SLED_MINOR_S * 1000)
`define SLED_SVC_ON_S      10
`define SLED_SVC_ON_MS     (`SLED_SVC_ON_S * 1000)
`define SLED_SVC_PER_S     60
`define SLED_SVC_PER_MS    (`SLED_SVC_PER_S * 1000)
`define SLED_SILENT_MIN    5
`define SLED_SILENT_MS     (`SLED_SILENT_MIN * 60000)
`define SLED_FAIL_MIN      1
`define SLED_FAIL_MS       (`SLED_FAIL_MIN * 60000)
`define SLED_SLOW_MS       1000
`define SLED_FAST_MS       200
`define SLED_LONG_MS       4000
`endif

/* File: include/sled_pkg.sv */
/*
  Types shared by the status indicator block.
  Assumes nothing beyond the block itself.
*/
package sled_pkg;
  typedef enum logic [2:0] {
    SLED_INIT, SLED_CONFIG, SLED_CALGAS, SLED_RUN, SLED_SEVERE
  } sled_mode_t;

  typedef enum logic [1:0] {
    SLED_SEV_RED, SLED_SEV_GREEN, SLED_SEV_ORANGE
  } sled_sev_t;

  // status inputs of one unit
  typedef struct packed {
    logic      init_done;
    logic      config_mode;
    logic      cal_gassing;
    logic      traffic;
    logic      packet_error;
    logic      severe;
    sled_sev_t severe_colour;
    logic      severe_solid;
    logic      service_due;
  } sled_unit_in_t;

  typedef struct packed {
    logic red;
    logic green;
  } sled_lamp_t;
endpackage

/* File: rtl/sled_unit.sv */
/*
  One indicator channel: pattern selection, fault hold, silence watchdog.
  Assumes a shared millisecond tick and blink phases from the parent.
*/
`timescale 1ns/100ps
`include "sled_cfg.svh"
module sled_unit
  import sled_pkg::*;
#(
  parameter int IS_SENSOR  = 0,
  parameter int MINOR_MS   = `SLED_MINOR_MS,
  parameter int SVC_ON_MS  = `SLED_SVC_ON_MS,
  parameter int SVC_PER_MS = `SLED_SVC_PER_MS,
  parameter int SILENT_MS  = `SLED_SILENT_MS,
  parameter int FAIL_MS    = `SLED_FAIL_MS
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // timing
  input  wire logic          tick,
  input  wire logic          slow_ph,
  input  wire logic          fast_ph,
  input  wire logic          long_ph,
  // unit status
  input  wire sled_unit_in_t st,
  input  wire logic          request,
  // outputs
  output sled_lamp_t         lamp,
  output logic               reboot,
  output logic               repair_text
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    sled_mode_t  mode;
    logic [18:0] minor_ms;
    logic [15:0] svc_ms;
    logic [18:0] quiet_ms;
    logic [16:0] fail_ms;
    sled_lamp_t  lamp;
    logic        reboot;
    logic        repair_text;
  } sled_unit_state_t;

  sled_unit_state_t s;
  sled_unit_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.reboot = 1'b0;
    // mode machine
    case (s.mode)
      SLED_INIT:   if (st.init_done) next_s.mode = SLED_RUN;
      SLED_SEVERE: if (!st.severe) next_s.mode = SLED_RUN;
      default: begin
        if (st.severe) next_s.mode = SLED_SEVERE;
        else if (st.config_mode) next_s.mode = SLED_CONFIG;
        else if (st.cal_gassing) next_s.mode = SLED_CALGAS;
        else next_s.mode = SLED_RUN;
      end
    endcase
    // minor fault hold, set wins over expiry
    if (st.packet_error) begin
      next_s.minor_ms = 19'(MINOR_MS);
    end else if (tick && s.minor_ms != 19'h0) begin
      next_s.minor_ms = s.minor_ms - 19'h1;
    end
    // service cycle
    if (!st.service_due) begin
      next_s.svc_ms = 16'h0;
    end else if (tick) begin
      next_s.svc_ms = (s.svc_ms >= 16'(SVC_PER_MS - 1)) ? 16'h0
                                                       : s.svc_ms + 16'h1;
    end
    // silence watchdog
    if (request || st.traffic) begin
      next_s.quiet_ms = 19'h0;
    end else if (tick) begin
      next_s.quiet_ms = s.quiet_ms + 19'h1;
    end
    if (tick && s.quiet_ms >= 19'(SILENT_MS - 1)) begin
      next_s.reboot   = 1'b1;
      next_s.mode     = SLED_INIT;
      next_s.quiet_ms = 19'h0;
    end
    // failure reboot
    if (s.mode != SLED_SEVERE) begin
      next_s.fail_ms = 17'h0;
    end else if (tick) begin
      next_s.fail_ms = s.fail_ms + 17'h1;
      if (s.fail_ms >= 17'(FAIL_MS - 1)) begin
        next_s.reboot  = 1'b1;
        next_s.mode    = SLED_INIT;
        next_s.fail_ms = 17'h0;
      end
    end
    // lamp pattern
    next_s.lamp = '0;
    case (s.mode)
      SLED_INIT:   next_s.lamp.red = slow_ph;
      SLED_CONFIG: begin
        next_s.lamp.green = slow_ph;
        next_s.lamp.red   = !slow_ph;
      end
      SLED_CALGAS: begin
        next_s.lamp.green = fast_ph;
        next_s.lamp.red   = !fast_ph;
      end
      SLED_SEVERE: begin
        next_s.lamp.red   = (st.severe_solid || long_ph) &&
                            st.severe_colour != SLED_SEV_GREEN;
        next_s.lamp.green = (st.severe_solid || long_ph) &&
                            st.severe_colour != SLED_SEV_RED;
      end
      SLED_RUN: begin
        if (s.minor_ms != 19'h0) begin
          next_s.lamp.red = fast_ph;
        end else if (st.service_due &&
                     s.svc_ms < 16'(SVC_ON_MS)) begin
          next_s.lamp.red = slow_ph;
        end else if (st.traffic || (IS_SENSOR != 0 && st.service_due))
        begin
          next_s.lamp.green = slow_ph;
        end else begin
          next_s.lamp.green = fast_ph;
        end
      end
      default: next_s.lamp = '0;
    endcase
    next_s.repair_text = st.service_due && (s.mode == SLED_RUN);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '{mode: SLED_INIT, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign lamp        = s.lamp;
  assign reboot      = s.reboot;
  assign repair_text = s.repair_text;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  minor_hold_a: assert property (
    st.packet_error |=> s.minor_ms == 19'(MINOR_MS))
    else $error("minor fault hold not loaded");
  minor_red_a: assert property (
    (s.mode == SLED_RUN && s.minor_ms != 19'h0 && !st.severe)
      |=> !lamp.green)
    else $error("green lit during minor fault");
  init_red_a: assert property (
    s.mode == SLED_INIT |=> lamp.red == $past(slow_ph) && !lamp.green)
    else $error("init pattern wrong");
  config_alt_a: assert property (
    s.mode == SLED_CONFIG |=> lamp.red != lamp.green)
    else $error("config not alternating");
  cal_alt_a: assert property (
    s.mode == SLED_CALGAS |=> lamp.green == $past(fast_ph))
    else $error("calibration pattern wrong");
  silent_reboot_a: assert property (
    reboot |-> s.mode == SLED_INIT)
    else $error("reboot did not enter init");
  sequence svc_on_s;
    s.mode == SLED_RUN && s.minor_ms == 19'h0 && st.service_due &&
    s.svc_ms < 16'(SVC_ON_MS);
  endsequence
  svc_red_a: assert property (
    svc_on_s |=> !lamp.green)
    else $error("service window shows green");
  repair_text_a: assert property (
    (st.service_due && s.mode == SLED_RUN) |=> repair_text)
    else $error("repair text not raised");
  sev_orange_a: assert property (
    (s.mode == SLED_SEVERE && st.severe_solid &&
     st.severe_colour == SLED_SEV_ORANGE) |=> lamp.red && lamp.green)
    else $error("orange not shown");
endmodule

/* File: rtl/sled_top.sv */
/*
  Status indicator block: transmitter and sensor bicolour lamps.
  Assumes status inputs synchronous to the 20 MHz clock.
*/
`timescale 1ns/100ps
`include "sled_cfg.svh"
module sled_top
  import sled_pkg::*;
#(
  parameter int TICK_CYC   = `SLED_TICK_CYC,
  parameter int SLOW_MS    = `SLED_SLOW_MS,
  parameter int FAST_MS    = `SLED_FAST_MS,
  parameter int LONG_MS    = `SLED_LONG_MS,
  parameter int MINOR_MS   = `SLED_MINOR_MS,
  parameter int SVC_ON_MS  = `SLED_SVC_ON_MS,
  parameter int SVC_PER_MS = `SLED_SVC_PER_MS,
  parameter int SILENT_MS  = `SLED_SILENT_MS,
  parameter int FAIL_MS    = `SLED_FAIL_MS
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // transmitter status
  input  wire sled_unit_in_t tx_st,
  // sensor status
  input  wire sled_unit_in_t sn_st,
  input  wire logic          sn_request,
  // lamps
  output sled_lamp_t         tx_lamp,
  output sled_lamp_t         sn_lamp,
  // reboots and display
  output logic               tx_reboot,
  output logic               sn_reboot,
  output logic               module_repair_due_text
);
  // ------------------------------------------------------------
  // blink timebase
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pre;
    logic        tick;
    logic [15:0] slow_ms;
    logic [15:0] fast_ms;
    logic [15:0] long_ms;
    logic        slow_ph;
    logic        fast_ph;
    logic        long_ph;
  } sled_tb_t;

  sled_tb_t t;
  sled_tb_t next_t;

  always_comb begin
    next_t      = t;
    next_t.tick = 1'b0;
    if (t.pre >= 16'(TICK_CYC - 1)) begin
      next_t.pre  = 16'h0;
      next_t.tick = 1'b1;
    end else begin
      next_t.pre = t.pre + 16'h1;
    end
    if (t.tick) begin
      // half period toggles, fast shorter than slow
      if (t.slow_ms >= 16'(SLOW_MS / 2 - 1)) begin
        next_t.slow_ms = 16'h0;
        next_t.slow_ph = !t.slow_ph;
      end else begin
        next_t.slow_ms = t.slow_ms + 16'h1;
      end
      if (t.fast_ms >= 16'(FAST_MS / 2 - 1)) begin
        next_t.fast_ms = 16'h0;
        next_t.fast_ph = !t.fast_ph;
      end else begin
        next_t.fast_ms = t.fast_ms + 16'h1;
      end
      if (t.long_ms >= 16'(LONG_MS / 2 - 1)) begin
        next_t.long_ms = 16'h0;
        next_t.long_ph = !t.long_ph;
      end else begin
        next_t.long_ms = t.long_ms + 16'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      t <= '0;
    end else begin
      t <= next_t;
    end
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  logic tx_text;
  logic sn_text;

  sled_unit #(
    .IS_SENSOR  (0),
    .MINOR_MS   (MINOR_MS),
    .SVC_ON_MS  (SVC_ON_MS),
    .SVC_PER_MS (SVC_PER_MS),
    .SILENT_MS  (SILENT_MS),
    .FAIL_MS    (FAIL_MS)
  ) u_tx (
    .clock       (clock),
    .nrst        (nrst),
    .tick        (t.tick),
    .slow_ph     (t.slow_ph),
    .fast_ph     (t.fast_ph),
    .long_ph     (t.long_ph),
    .st          (tx_st),
    .request     (1'b0),
    .lamp        (tx_lamp),
    .reboot      (tx_reboot),
    .repair_text (tx_text)
  );

  sled_unit #(
    .IS_SENSOR  (1),
    .MINOR_MS   (MINOR_MS),
    .SVC_ON_MS  (SVC_ON_MS),
    .SVC_PER_MS (SVC_PER_MS),
    .SILENT_MS  (SILENT_MS),
    .FAIL_MS    (FAIL_MS)
  ) u_sn (
    .clock       (clock),
    .nrst        (nrst),
    .tick        (t.tick),
    .slow_ph     (t.slow_ph),
    .fast_ph     (t.fast_ph),
    .long_ph     (t.long_ph),
    .st          (sn_st),
    .request     (sn_request),
    .lamp        (sn_lamp),
    .reboot      (sn_reboot),
    .repair_text (sn_text)
  );

  assign module_repair_due_text = tx_text || sn_text;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  tick_period_a: assert property (
    t.tick |=> !t.tick)
    else $error("tick lasted two cycles");
  fast_shorter_a: assert property (
    $changed(t.slow_ph) |-> $changed(t.fast_ph))
    else $error("slow phase toggled without a fast toggle");
endmodule

/* File: testbench/sled_eye.sv */
/*
  Lamp observer: counts rises and lit cycles of one bicolour lamp.
  Assumes the bench pulses clr at the start of each window.
*/
`timescale 1ns/100ps
module sled_eye
  import sled_pkg::*;
(
  // clock
  input  wire logic       clock,
  // lamp and window control
  input  wire sled_lamp_t lamp,
  input  wire logic       clr,
  // counts
  output logic [15:0]     red_rise,
  output logic [15:0]     green_rise,
  output logic [15:0]     red_on,
  output logic [15:0]     green_on,
  output logic [15:0]     both_on
);
  sled_lamp_t last = '0;
  always @(posedge clock) begin
    last <= lamp;
    if (clr) begin
      {red_rise, green_rise, red_on, green_on, both_on} <= '0;
    end else begin
      red_rise   <= red_rise + 16'(lamp.red & ~last.red);
      green_rise <= green_rise + 16'(lamp.green & ~last.green);
      red_on     <= red_on + 16'(lamp.red);
      green_on   <= green_on + 16'(lamp.green);
      both_on    <= both_on + 16'(lamp.red & lamp.green);
    end
  end
endmodule

/* File: testbench/status_led_indicator_bench.sv */
/*
  Self-checking bench for the status indicator block.
  Assumes shortened timing parameters; one tick is 4 clocks.
*/
`timescale 1ns/100ps
module status_led_indicator_bench
  import sled_pkg::*;
;
  localparam int TK = 4;
  localparam int SIL = 50;
  localparam int FAIL = 20;
  localparam int MINOR = 10;
  logic          clock = 1'b0;
  logic          nrst = 1'b0;
  logic          clr = 1'b0;
  logic          req_on = 1'b0;
  logic          sn_request = 1'b0;
  logic [31:0]   lf = 32'h2649;
  sled_unit_in_t tx_st = '0;
  sled_unit_in_t sn_st = '0;
  sled_lamp_t    tx_lamp, sn_lamp;
  logic          tx_reboot, sn_reboot, text;
  logic [15:0]   rr[2], gr[2], ro[2], go[2], bo[2];
  logic [15:0]   slow0;
  int            fail_count = 0;
  int            n_compared = 0;
  int            c;

  always #25 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // random request pulses on the sensor link
  always @(posedge clock) begin
    lf <= lfsr(lf);
    sn_request <= req_on & lf[0];
  end

  sled_top #(.TICK_CYC(TK), .SLOW_MS(8), .FAST_MS(4), .LONG_MS(16),
    .MINOR_MS(MINOR), .SVC_ON_MS(5), .SVC_PER_MS(20), .SILENT_MS(SIL),
    .FAIL_MS(FAIL)) DUT (
    .clock(clock), .nrst(nrst), .tx_st(tx_st), .sn_st(sn_st),
    .sn_request(sn_request), .tx_lamp(tx_lamp), .sn_lamp(sn_lamp),
    .tx_reboot(tx_reboot), .sn_reboot(sn_reboot),
    .module_repair_due_text(text));

  for (genvar u = 0; u < 2; u++) begin : g_eye
    sled_eye eye (.clock(clock), .lamp(u == 0 ? tx_lamp : sn_lamp),
      .clr(clr), .red_rise(rr[u]), .green_rise(gr[u]), .red_on(ro[u]),
      .green_on(go[u]), .both_on(bo[u]));
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] near(input logic [15:0] v, input int e);
    return (int'(v) >= e - 1 && int'(v) <= e + 1) ? 16'h1 : 16'h0;
  endfunction

  // expected rises per colour; zero means that colour stays dark
  task automatic pat(input int u, input int er, input int eg, input bit alt);
    if (er == 0) check(ro[u], 16'h0);
    else check(near(rr[u], er), 16'h1);
    if (eg == 0) check(go[u], 16'h0);
    else check(near(gr[u], eg), 16'h1);
    if (alt) check(bo[u], 16'h0);
  endtask

  task automatic settle(input int ms);
    repeat (ms * TK) @(posedge clock);
  endtask

  task automatic watch(input int ms);
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    settle(ms);
    #1;
  endtask

  task automatic boot(input logic sn, input int ms);
    int n;
    n = 0;
    while (n < ms * TK && (sn ? sn_reboot : tx_reboot) !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(16'(n < ms * TK), 16'h1);
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (3000 * TK) @(posedge clock);
    fail_count++;
    test_done;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    watch(32);
    pat(1, 4, 0, 0);
    @(posedge clock);
    {tx_st.init_done, tx_st.traffic, sn_st.init_done, sn_st.traffic} <= '1;
    req_on <= 1'b1;
    settle(2);
    watch(32);
    pat(0, 0, 4, 0);
    pat(1, 0, 4, 0);
    slow0 = gr[0];
    @(posedge clock);
    {tx_st.config_mode, sn_st.config_mode} <= 2'b11;
    settle(2);
    watch(32);
    pat(0, 4, 4, 1);
    pat(1, 4, 4, 1);
    @(posedge clock);
    {tx_st.config_mode, sn_st.config_mode} <= 2'b00;
    {tx_st.cal_gassing, sn_st.cal_gassing} <= 2'b11;
    settle(2);
    watch(32);
    pat(0, 8, 8, 1);
    pat(1, 8, 8, 1);
    @(posedge clock);
    {tx_st.cal_gassing, sn_st.cal_gassing} <= 2'b00;
    for (int u = 0; u < 2; u++) begin
      settle(2);
      if (u == 0) tx_st.packet_error <= 1'b1;
      else sn_st.packet_error <= 1'b1;
      @(posedge clock);
      {tx_st.packet_error, sn_st.packet_error} <= 2'b00;
      watch(8);
      if (u == 0) pat(0, 2, 0, 0);
      else pat(1, 2, 0, 0);
      settle(10);
      watch(16);
      pat(u, 0, 2, 0);
    end
    @(posedge clock);
    sn_st.service_due <= 1'b1;
    settle(2);
    check(16'(text), 16'h1);
    watch(40);
    check(16'(rr[1] != 0), 16'h1);
    check(16'(gr[1] != 0), 16'h1);
    @(posedge clock);
    sn_st.service_due <= 1'b0;
    settle(2);
    check(16'(text), 16'h0);
    c = int'(lf % 3);
    sn_st.severe <= 1'b1;
    sn_st.severe_colour <= sled_sev_t'(c);
    sn_st.severe_solid <= 1'b1;
    settle(1);
    watch(8);
    check(ro[1], c != 1 ? 16'(8 * TK) : 16'h0);
    check(go[1], c != 0 ? 16'(8 * TK) : 16'h0);
    boot(1'b1, FAIL);
    @(posedge clock);
    sn_st.severe <= 1'b0;
    // long-period severe pattern on the transmitter lamp
    tx_st.severe <= 1'b1;
    tx_st.severe_colour <= sled_sev_t'(c);
    settle(1);
    watch(12);
    check(16'(ro[0] != 0 && ro[0] < 16'(12 * TK)), 16'(c != 1));
    check(16'(go[0] != 0 && go[0] < 16'(12 * TK)), 16'(c != 0));
    @(posedge clock);
    tx_st.severe <= 1'b0;
    settle(2);
    {tx_st.traffic, sn_st.traffic, req_on} <= 3'b000;
    {tx_st.init_done, sn_st.init_done} <= 2'b00;
    settle(2);
    watch(32);
    pat(0, 0, 8, 0);
    pat(1, 0, 8, 0);
    check(16'(gr[0] > slow0), 16'h1);
    fork
      boot(1'b0, SIL);
      boot(1'b1, SIL);
    join
    watch(32);
    pat(1, 4, 0, 0);
    test_done;
  end
endmodule
